// ==== inc/mau_pkg.sv ====
// Constants and encodings of the multiply-accumulate unit
package mau_pkg;

   // Data widths
   localparam int unsigned DW     = 16;
   localparam int unsigned PW     = 32;
   localparam int unsigned AW     = 36;
   localparam int unsigned CTR_W  = 8;
   localparam int unsigned RA_W   = 5;

   // Register word addresses
   localparam logic [4:0] ADDR_X    = 5'h00;
   localparam logic [4:0] ADDR_Y    = 5'h01;
   localparam logic [4:0] ADDR_YL   = 5'h02;
   localparam logic [4:0] ADDR_P    = 5'h03;
   localparam logic [4:0] ADDR_PL   = 5'h04;
   localparam logic [4:0] ADDR_A0   = 5'h05;
   localparam logic [4:0] ADDR_A0L  = 5'h06;
   localparam logic [4:0] ADDR_A1   = 5'h07;
   localparam logic [4:0] ADDR_A1L  = 5'h08;
   localparam logic [4:0] ADDR_AUC  = 5'h09;
   localparam logic [4:0] ADDR_PSW  = 5'h0A;
   localparam logic [4:0] ADDR_C0   = 5'h0B;
   localparam logic [4:0] ADDR_PI   = 5'h0E;

   // Arithmetic control register fields
   localparam int unsigned AUC_CLR_Y   = 0;
   localparam int unsigned AUC_CLR_A0  = 1;
   localparam int unsigned AUC_CLR_A1  = 2;
   localparam int unsigned AUC_SAT_A0  = 3;
   localparam int unsigned AUC_SAT_A1  = 4;
   localparam int unsigned AUC_ALN_LO  = 5;
   localparam int unsigned AUC_ALN_HI  = 6;
   localparam int unsigned AUC_SQUARE  = 7;
   localparam int unsigned AUC_PSG_RST = 8;
   localparam logic [15:0] AUC_RESET   = 16'h0000;
   localparam logic [15:0] AUC_MASK    = 16'h01FF;

   // Status word fields: guard nibbles and four flags
   localparam int unsigned PSW_G0_LO  = 0;
   localparam int unsigned PSW_G1_LO  = 4;
   localparam int unsigned PSW_FLG_LO = 12;

   // Saturation limits and rounding constant
   localparam logic [35:0] SAT_POS = 36'h0_7FFF_FFFF;
   localparam logic [35:0] SAT_NEG = 36'hF_8000_0000;
   localparam logic [36:0] RND_ADD = 37'h00_0000_8000;

   // Shift distances selected by the 2-bit shift code
   localparam int unsigned SH_0 = 1;
   localparam int unsigned SH_1 = 4;
   localparam int unsigned SH_2 = 8;
   localparam int unsigned SH_3 = 16;

   typedef enum logic [3:0] {
      MAU_OP_ADD = 4'h0,
      MAU_OP_SUB = 4'h1,
      MAU_OP_AND = 4'h2,
      MAU_OP_OR  = 4'h3,
      MAU_OP_XOR = 4'h4,
      MAU_OP_RND = 4'h5,
      MAU_OP_NEG = 4'h6,
      MAU_OP_INC = 4'h7,
      MAU_OP_SHL = 4'h8,
      MAU_OP_SHR = 4'h9
   } mau_alu_op_e;

   typedef enum logic [2:0] {
      MAU_SRC_Y   = 3'h0,
      MAU_SRC_P   = 3'h1,
      MAU_SRC_A0  = 3'h2,
      MAU_SRC_A1  = 3'h3,
      MAU_SRC_IMM = 3'h4
   } mau_src_e;

   typedef enum logic [1:0] {
      MAU_YSRC_DATA = 2'h0,
      MAU_YSRC_AHI  = 2'h1,
      MAU_YSRC_ALO  = 2'h2
   } mau_ysrc_e;

   typedef enum logic [1:0] {
      MAU_ALN_X1   = 2'h0,
      MAU_ALN_DIV4 = 2'h1,
      MAU_ALN_X4   = 2'h2,
      MAU_ALN_X2   = 2'h3
   } mau_align_e;

endpackage

// ==== core/mau_loop_ctr.sv ====
// Signed 8-bit loop counter with load and step
`timescale 1ns/1ps
module mau_loop_ctr (
   input  wire logic                       ref_clk_i,
   input  wire logic                       reset_i,
   input  wire logic                       load_i,
   input  wire logic [mau_pkg::CTR_W-1:0]  load_val_i,
   input  wire logic                       step_i,
   output logic      [mau_pkg::CTR_W-1:0]  count_o
);

   // Load wins over a step
   // (RULE_16) load and step
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         count_o <= 8'h00;
      end else if (load_i) begin
         count_o <= load_val_i;
      end else if (step_i) begin
         count_o <= count_o + 8'h01;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   a_ctr_step_inc: assert property (  // RULE_16
      step_i && !load_i |=> count_o == $past(count_o) + 8'h01)
      else $error("counter step wrong");
   a_ctr_load_val: assert property (  // RULE_16
      load_i |=> count_o == $past(load_val_i))
      else $error("counter load lost");
   c_ctr_wrap: cover property (step_i && !load_i && count_o == 8'h7F);

endmodule

// ==== core/mau_arith_datapath.sv ====
// Multiply-accumulate datapath: multiplier, 36-bit ALU, accumulators
//
// Summary of operation
// (RULE_01) Signed 16x16 product into 32-bit register
// (RULE_02) Multiplier takes coefficient and second-operand high
// (RULE_03) Coefficient register loads from program or data
// (RULE_04) Second-operand high loads from data or accumulator
// (RULE_05) Square mode copies second-operand loads to coefficient
// (RULE_06) Plain name is high half, low name low
// (RULE_07) ALU takes y, product, accumulators, immediate, 36-bit
// (RULE_08) Add, subtract, AND, OR, XOR
// (RULE_09) Round, negate, increment, shifts 1/4/8/16
// (RULE_10) Control bit clears low word on high write
// (RULE_11) Control bit enables accumulator saturation
// (RULE_12) Control field picks one of four product alignments
// (RULE_13) Control bit: return-register write resets noise generator
// (RULE_14) Control register clears to zero at reset
// (RULE_15) Status word holds flags and guard bits
// (RULE_16) Three signed 8-bit loop counters
// (RULE_17) Multiply and accumulate together in one cycle
// (RULE_18) Two 36-bit two's complement accumulators
// (RULE_19) Saturation loads largest value of result sign
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module mau_arith_datapath (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic [4:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   input  wire logic        ins_valid_i,
   input  wire logic        mul_en_i,
   input  wire logic        x_load_i,
   input  wire logic        x_src_data_i,
   input  wire logic [15:0] coef_data_i,
   input  wire logic [15:0] ydata_i,
   input  wire logic        y_load_i,
   input  wire logic [1:0]  y_src_i,
   input  wire logic        y_acc_sel_i,
   input  wire logic        alu_en_i,
   input  wire logic [3:0]  alu_op_i,
   input  wire logic        alu_a_sel_i,
   input  wire logic [2:0]  alu_b_sel_i,
   input  wire logic [1:0]  alu_shift_i,
   input  wire logic [15:0] alu_imm_i,
   input  wire logic        alu_dst_i,
   input  wire logic        ctr_step_i,
   input  wire logic        ctr_test_i,
   input  wire logic [1:0]  ctr_sel_i,
   output logic [35:0]      accum_zero_o,
   output logic [35:0]      accum_one_o,
   output logic [3:0]       alu_flags_o,
   output logic             loop_neg_o,
   output logic             psg_reset_o
);

   logic [15:0] x;
   logic [31:0] y;
   logic [31:0] p;
   logic [35:0] acc [2];
   logic [15:0] auc;
   logic [15:0] int_return_reg;
   logic [7:0]  cnt [3];

   // Decoded bus writes
   logic        bus_x;
   logic        bus_y;
   logic        bus_yl;
   logic        bus_psw;
   logic        ins_y;
   logic        y_hi_load;
   logic [15:0] y_hi_val;
   logic [15:0] acc_pick_hi;
   logic [15:0] acc_pick_lo;

   assign bus_x   = reg_wr_i && reg_addr_i == mau_pkg::ADDR_X;
   assign bus_y   = reg_wr_i && reg_addr_i == mau_pkg::ADDR_Y;
   assign bus_yl  = reg_wr_i && reg_addr_i == mau_pkg::ADDR_YL;
   assign bus_psw = reg_wr_i && reg_addr_i == mau_pkg::ADDR_PSW;
   assign ins_y   = ins_valid_i && y_load_i;
   assign y_hi_load   = bus_y || ins_y;
   assign acc_pick_hi = acc[y_acc_sel_i][31:16];
   assign acc_pick_lo = acc[y_acc_sel_i][15:0];

   // Source of a second-operand high load
   // (RULE_04) data or accumulator half
   always_comb begin
      y_hi_val = ydata_i;
      if (bus_y) begin
         y_hi_val = reg_wdata_i;
      end else if (y_src_i == mau_pkg::MAU_YSRC_AHI) begin
         y_hi_val = acc_pick_hi;
      end else if (y_src_i == mau_pkg::MAU_YSRC_ALO) begin
         y_hi_val = acc_pick_lo;
      end
   end

   // Coefficient register
   // (RULE_03) program or data source
   // (RULE_05) square mode copy
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         x <= 16'h0000;
      end else if (bus_x) begin
         x <= reg_wdata_i;
      end else if (auc[mau_pkg::AUC_SQUARE] && y_hi_load) begin
         x <= y_hi_val;
      end else if (ins_valid_i && x_load_i) begin
         x <= x_src_data_i ? ydata_i : coef_data_i;
      end
   end

   // Second-operand register halves
   // (RULE_10) optional low clear
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         y <= 32'h0000_0000;
      end else begin
         if (y_hi_load) begin
            y[31:16] <= y_hi_val;
            if (auc[mau_pkg::AUC_CLR_Y]) begin
               y[15:0] <= 16'h0000;
            end
         end
         if (bus_yl) begin
            y[15:0] <= reg_wdata_i;
         end
      end
   end

   // Product register, beside the ALU
   // (RULE_01) signed product
   // (RULE_17) concurrent with ALU
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         p <= 32'h0000_0000;
      end else if (reg_wr_i && reg_addr_i == mau_pkg::ADDR_P) begin
         p[31:16] <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == mau_pkg::ADDR_PL) begin
         p[15:0] <= reg_wdata_i;
      end else if (ins_valid_i && mul_en_i) begin
         // (RULE_02) coefficient times second high
         p <= $signed(x) * $signed(y[31:16]);
      end
   end

   // ALU operand selection and result
   logic [31:0] p_al;
   logic [35:0] opa;
   logic [35:0] opb;
   logic [36:0] res;
   logic [36:0] tmp;
   logic        ovf32;
   logic        sat_en;
   logic        res_sign;
   logic [35:0] alu_out;
   int unsigned sh;

   // (RULE_12) product alignment
   always_comb begin
      unique case (mau_pkg::mau_align_e'(auc[mau_pkg::AUC_ALN_HI:
                                              mau_pkg::AUC_ALN_LO]))
         mau_pkg::MAU_ALN_X1:   p_al = p;
         mau_pkg::MAU_ALN_DIV4: p_al = 32'($signed(p) >>> 2);
         mau_pkg::MAU_ALN_X4:   p_al = p << 2;
         mau_pkg::MAU_ALN_X2:   p_al = p << 1;
      endcase
   end

   // (RULE_07) operand sources, sign extended
   always_comb begin
      opa = acc[alu_a_sel_i];
      unique case (alu_b_sel_i)
         mau_pkg::MAU_SRC_Y:  opb = {{4{y[31]}}, y};
         mau_pkg::MAU_SRC_P:  opb = {{4{p_al[31]}}, p_al};
         mau_pkg::MAU_SRC_A0: opb = acc[0];
         mau_pkg::MAU_SRC_A1: opb = acc[1];
         default:             opb = {{4{alu_imm_i[15]}}, alu_imm_i, 16'h0000};
      endcase
      unique case (alu_shift_i)
         2'h0: sh = mau_pkg::SH_0;
         2'h1: sh = mau_pkg::SH_1;
         2'h2: sh = mau_pkg::SH_2;
         2'h3: sh = mau_pkg::SH_3;
      endcase
   end

   // (RULE_08) dyadic operations
   // (RULE_09) monadic operations
   always_comb begin
      tmp = {opa[35], opa} + mau_pkg::RND_ADD;
      unique case (alu_op_i)
         mau_pkg::MAU_OP_ADD: res = {opa[35], opa} + {opb[35], opb};
         mau_pkg::MAU_OP_SUB: res = {opa[35], opa} - {opb[35], opb};
         mau_pkg::MAU_OP_AND: res = {opa[35] & opb[35], opa & opb};
         mau_pkg::MAU_OP_OR:  res = {opa[35] | opb[35], opa | opb};
         mau_pkg::MAU_OP_XOR: res = {opa[35] ^ opb[35], opa ^ opb};
         mau_pkg::MAU_OP_RND: res = {tmp[36:16], 16'h0000};
         mau_pkg::MAU_OP_NEG: res = 37'h0 - {opa[35], opa};
         mau_pkg::MAU_OP_INC: res = {opa[35], opa} + 37'h1;
         mau_pkg::MAU_OP_SHL: res = {opa[35], opa} << sh;
         mau_pkg::MAU_OP_SHR: res = 37'($signed({opa[35], opa}) >>> sh);
         default:             res = {opa[35], opa};
      endcase
   end

   // (RULE_11) saturation enable per accumulator
   // (RULE_19) clamp by true result sign
   assign res_sign = res[36];
   assign ovf32    = !(&res[35:31] || !(|res[35:31]));
   assign sat_en   = alu_dst_i ? auc[mau_pkg::AUC_SAT_A1]
                               : auc[mau_pkg::AUC_SAT_A0];
   assign alu_out  = (sat_en && ovf32)
                   ? (res_sign ? mau_pkg::SAT_NEG : mau_pkg::SAT_POS)
                   : res[35:0];

   // Accumulators: ALU result, bus writes win
   // (RULE_18) two 36-bit accumulators
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         acc[0] <= 36'h0_0000_0000;
         acc[1] <= 36'h0_0000_0000;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (ins_valid_i && alu_en_i && alu_dst_i == 1'(i)) begin
               // (RULE_07) single-cycle result
               acc[i] <= alu_out;
            end
            // (RULE_06) high and low word moves
            if (reg_wr_i && reg_addr_i == (i == 0 ? mau_pkg::ADDR_A0
                                                  : mau_pkg::ADDR_A1)) begin
               acc[i][35:16] <= {{4{reg_wdata_i[15]}}, reg_wdata_i};
               // (RULE_10) optional low clear
               if (auc[mau_pkg::AUC_CLR_A0 + i]) begin
                  acc[i][15:0] <= 16'h0000;
               end
            end
            if (reg_wr_i && reg_addr_i == (i == 0 ? mau_pkg::ADDR_A0L
                                                  : mau_pkg::ADDR_A1L)) begin
               acc[i][15:0] <= reg_wdata_i;
            end
            // (RULE_15) guard bits from status word
            if (bus_psw) begin
               acc[i][35:32] <= reg_wdata_i[4*i +: 4];
            end
         end
      end
   end

   assign accum_zero_o = acc[0];
   assign accum_one_o  = acc[1];

   // Flags: negative, zero, 36-bit overflow, 32-bit overflow
   // (RULE_15) flag capture
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         alu_flags_o <= 4'h0;
      end else if (bus_psw) begin
         alu_flags_o <= reg_wdata_i[mau_pkg::PSW_FLG_LO +: 4];
      end else if (ins_valid_i && alu_en_i) begin
         alu_flags_o <= {alu_out[35], alu_out == 36'h0,
                         res[36] ^ res[35], ovf32};
      end
   end

   // Control register
   // (RULE_14) cleared by reset
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         auc <= mau_pkg::AUC_RESET;
      end else if (reg_wr_i && reg_addr_i == mau_pkg::ADDR_AUC) begin
         auc <= reg_wdata_i & mau_pkg::AUC_MASK;
      end
   end

   // Return register, generator reset pulse
   // (RULE_13) reset on return-register write
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         int_return_reg <= 16'h0000;
         psg_reset_o    <= 1'b0;
      end else begin
         psg_reset_o <= 1'b0;
         if (reg_wr_i && reg_addr_i == mau_pkg::ADDR_PI) begin
            int_return_reg <= reg_wdata_i;
            psg_reset_o    <= auc[mau_pkg::AUC_PSG_RST];
         end
      end
   end

   // Loop counters
   // (RULE_16) three counters
   for (genvar g = 0; g < 3; g++) begin : g_ctr
      mau_loop_ctr u_ctr (
         .ref_clk_i  (ref_clk_i),
         .reset_i    (reset_i),
         .load_i     (reg_wr_i && reg_addr_i == mau_pkg::ADDR_C0 + 5'(g)),
         .load_val_i (reg_wdata_i[7:0]),
         .step_i     (ins_valid_i && ctr_step_i && ctr_sel_i == 2'(g)),
         .count_o    (cnt[g])
      );
   end

   // Test holds the pre-step counter sign
   // (RULE_16) conditional test
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         loop_neg_o <= 1'b0;
      end else if (ins_valid_i && ctr_test_i && ctr_sel_i != 2'h3) begin
         loop_neg_o <= cnt[ctr_sel_i][7];
      end
   end

   // Read data, one cycle after the strobe
   // (RULE_06) half-word views
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !reg_rd_i) begin
         reg_rdata_o <= 16'h0000;
      end else begin
         unique case (reg_addr_i)
            mau_pkg::ADDR_X:   reg_rdata_o <= x;
            mau_pkg::ADDR_Y:   reg_rdata_o <= y[31:16];
            mau_pkg::ADDR_YL:  reg_rdata_o <= y[15:0];
            mau_pkg::ADDR_P:   reg_rdata_o <= p[31:16];
            mau_pkg::ADDR_PL:  reg_rdata_o <= p[15:0];
            mau_pkg::ADDR_A0:  reg_rdata_o <= acc[0][31:16];
            mau_pkg::ADDR_A0L: reg_rdata_o <= acc[0][15:0];
            mau_pkg::ADDR_A1:  reg_rdata_o <= acc[1][31:16];
            mau_pkg::ADDR_A1L: reg_rdata_o <= acc[1][15:0];
            mau_pkg::ADDR_AUC: reg_rdata_o <= auc;
            mau_pkg::ADDR_PSW: reg_rdata_o <= {alu_flags_o, 4'h0,
                                               acc[1][35:32], acc[0][35:32]};
            mau_pkg::ADDR_PI:  reg_rdata_o <= int_return_reg;
            5'h0B:             reg_rdata_o <= {8'h00, cnt[0]};
            5'h0C:             reg_rdata_o <= {8'h00, cnt[1]};
            5'h0D:             reg_rdata_o <= {8'h00, cnt[2]};
            default:           reg_rdata_o <= 16'h0000;
         endcase
      end
   end

   // Checks on the datapath
   logic bus_a0;
   assign bus_a0 = reg_wr_i && (reg_addr_i == mau_pkg::ADDR_A0
                 || reg_addr_i == mau_pkg::ADDR_A0L || bus_psw);

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   a_mult_product: assert property (  // RULE_01
      ins_valid_i && mul_en_i && !(reg_wr_i && (reg_addr_i ==
      mau_pkg::ADDR_P || reg_addr_i == mau_pkg::ADDR_PL))
      |=> $signed(p) == $signed($past(x)) * $signed($past(y[31:16])))
      else $error("product wrong");
   a_x_coef_load: assert property (  // RULE_03
      ins_valid_i && x_load_i && !x_src_data_i && !bus_x
      && !(auc[mau_pkg::AUC_SQUARE] && y_hi_load)
      |=> x == $past(coef_data_i))
      else $error("coefficient load lost");
   a_y_from_acc: assert property (  // RULE_04
      ins_y && !bus_y && y_src_i == mau_pkg::MAU_YSRC_AHI
      |=> y[31:16] == $past(acc_pick_hi))
      else $error("second operand load lost");
   a_square_copy: assert property (  // RULE_05
      auc[mau_pkg::AUC_SQUARE] && y_hi_load && !bus_x
      |=> x == y[31:16])
      else $error("square copy lost");
   a_low_half_read: assert property (  // RULE_06
      reg_rd_i && reg_addr_i == mau_pkg::ADDR_A0L
      |=> reg_rdata_o == $past(acc[0][15:0]) ##1 reg_rdata_o == 16'h0000
      || $past(reg_rd_i))
      else $error("low half read wrong");
   a_alu_add_acc: assert property (  // RULE_08
      ins_valid_i && alu_en_i && !alu_dst_i && !sat_en && !bus_a0
      && alu_op_i == mau_pkg::MAU_OP_ADD |=> acc[0] == $past(opa + opb))
      else $error("add result wrong");
   a_y_low_clear: assert property (  // RULE_10
      bus_y && auc[mau_pkg::AUC_CLR_Y] && !bus_yl |=> y[15:0] == 16'h0000)
      else $error("low word not cleared");
   a_sat_clamp: assert property (  // RULE_19
      ins_valid_i && alu_en_i && !alu_dst_i && sat_en && ovf32 && !bus_a0
      |=> acc[0] == ($past(res_sign) ? mau_pkg::SAT_NEG : mau_pkg::SAT_POS))
      else $error("saturation wrong");
   a_auc_reset: assert property (disable iff (1'b0)  // RULE_14
      reset_i |=> auc == mau_pkg::AUC_RESET)
      else $error("control not cleared");
   a_psg_pulse: assert property (  // RULE_13
      reg_wr_i && reg_addr_i == mau_pkg::ADDR_PI
      |=> psg_reset_o == $past(auc[mau_pkg::AUC_PSG_RST]) ##1 !psg_reset_o
      || $past(reg_wr_i))
      else $error("generator pulse wrong");
   a_guard_write: assert property (  // RULE_15
      bus_psw && !(ins_valid_i && alu_en_i)
      |=> acc[0][35:32] == $past(reg_wdata_i[3:0]))
      else $error("guard write lost");

   c_mac_cycle: cover property (ins_valid_i && mul_en_i && alu_en_i
                                && alu_b_sel_i == mau_pkg::MAU_SRC_P);
   c_saturate:  cover property (ins_valid_i && alu_en_i && sat_en && ovf32);
   c_square:    cover property (auc[mau_pkg::AUC_SQUARE] && ins_y);
   c_loop_neg:  cover property (ins_valid_i && ctr_test_i && cnt[0][7]);

endmodule

// ==== verif/mau_mem_model.sv ====
// Memory bus model: program and data words for the datapath
`timescale 1ns/1ps
module mau_mem_model (
   input  wire logic        ref_clk_i,
   input  wire logic        rd_i,
   input  wire logic [1:0]  addr_i,
   output logic      [15:0] coef_o,
   output logic      [15:0] data_o
);
   logic [15:0] rom [4] = '{16'hFFFE, 16'h0003, 16'h0005, 16'h8000};
   logic [15:0] last = 16'h0000;
   // Last word read
   always @(posedge ref_clk_i) begin
      if (rd_i) begin
         last <= rom[addr_i];
      end
   end
   // Released buses show its inverse
   assign coef_o = rd_i ? rom[addr_i] : ~last;
   assign data_o = rd_i ? rom[addr_i ^ 2'h1] : ~last;
endmodule

// ==== verif/test_multiply_accumulate_unit.sv ====
// Self-checking bench for the multiply-accumulate unit
`timescale 1ns/1ps
module test_multiply_accumulate_unit;
   logic        ref_clk_i, reset_i, reg_wr_i, reg_rd_i, ins_valid_i;
   logic        mul_en_i, x_load_i, x_src_data_i, y_load_i, y_acc_sel_i;
   logic        alu_en_i, alu_a_sel_i, alu_dst_i, ctr_step_i, ctr_test_i;
   logic        loop_neg_o, psg_reset_o, mrd;
   logic [1:0]  y_src_i, alu_shift_i, ctr_sel_i, maddr;
   logic [2:0]  alu_b_sel_i;
   logic [3:0]  alu_op_i, alu_flags_o, o;
   logic [4:0]  reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, coef_data_i, ydata_i, alu_imm_i;
   logic [35:0] accum_zero_o, accum_one_o, a, e;
   int          n_fail, compares, s;
   int          sh [4] = '{1, 4, 8, 16};

   // Datapath and its memory buses
   mau_arith_datapath dut_u (.ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ins_valid_i, .mul_en_i, .x_load_i,
      .x_src_data_i, .coef_data_i, .ydata_i, .y_load_i, .y_src_i, .y_acc_sel_i,
      .alu_en_i, .alu_op_i, .alu_a_sel_i, .alu_b_sel_i, .alu_shift_i,
      .alu_imm_i, .alu_dst_i, .ctr_step_i, .ctr_test_i, .ctr_sel_i,
      .accum_zero_o, .accum_one_o, .alu_flags_o, .loop_neg_o, .psg_reset_o);
   mau_mem_model mem_u (.ref_clk_i, .rd_i(mrd), .addr_i(maddr),
      .coef_o(coef_data_i), .data_o(ydata_i));

   // Clock, 4 ns period
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   // Compare one result and count it
   task automatic chk(input logic [35:0] g, input logic [35:0] x);
      compares++;
      if (g !== x) begin
         n_fail++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
      end
   endtask

   // Verdict and end of run
   task automatic complete_run();
      if (n_fail == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Register write and checked read
   task automatic wr(input logic [4:0] ad, input logic [15:0] d);
      @(posedge ref_clk_i);
      {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, ad, d};
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [4:0] ad, input logic [15:0] x);
      @(posedge ref_clk_i);
      {reg_rd_i, reg_addr_i} <= {1'b1, ad};
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk({20'h0, reg_rdata_o}, {20'h0, x});
   endtask

   // One instruction cycle
   task automatic go();
      ins_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      {ins_valid_i, mul_en_i, x_load_i, y_load_i} <= '0;
      {alu_en_i, ctr_step_i, ctr_test_i, mrd} <= '0;
      #1;
   endtask
   task automatic alu(input logic [3:0] op, input logic [2:0] b,
                      input logic [15:0] im, input logic as, input logic d);
      @(posedge ref_clk_i);
      {alu_en_i, alu_op_i, alu_b_sel_i, alu_imm_i} <= {1'b1, op, b, im};
      {alu_a_sel_i, alu_dst_i} <= {as, d};
   endtask

   // Expected ALU result
   function automatic logic [35:0] expv(input logic [3:0] op, input int n,
                                        input logic [35:0] x, y);
      case (op)
         4'h0: return x + y;
         4'h1: return x - y;
         4'h2: return x & y;
         4'h3: return x | y;
         4'h4: return x ^ y;
         4'h5: return (x + 36'h8000) & 36'hF_FFFF_0000;
         4'h6: return -x;
         4'h7: return x + 36'h1;
         4'h8: return x << n;
         default: return 36'($signed(x) >>> n);
      endcase
   endfunction

   // Reset clears control; unmapped reads 0
   task automatic t_reset();
      wr(mau_pkg::ADDR_AUC, 16'hFFFF);
      rdc(mau_pkg::ADDR_AUC, 16'h01FF);
      @(posedge ref_clk_i) reset_i <= 1'b1;
      @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rdc(mau_pkg::ADDR_AUC, 16'h0000);
      wr(5'h1F, 16'hFFFF);
      rdc(5'h1F, 16'h0000);
   endtask

   // Signed product and four alignments
   task automatic t_mult();
      @(posedge ref_clk_i);
      {mrd, maddr, x_load_i, y_load_i, y_src_i} <= {4'h9, 1'b1, 2'h0};
      go();
      @(posedge ref_clk_i);
      mul_en_i <= 1'b1;
      go();
      rdc(mau_pkg::ADDR_P, 16'hFFFF);
      rdc(mau_pkg::ADDR_PL, 16'hFFFA);
      alu(4'h2, 3'h4, 16'h0000, 1'b1, 1'b1);
      go();
      a = 36'hF_FFFF_FFFA;
      for (int k = 0; k < 4; k++) begin
         wr(mau_pkg::ADDR_AUC, 16'(k << 5));
         alu(4'h0, 3'h1, 16'h0000, 1'b1, 1'b0);
         go();
         e = k == 1 ? 36'($signed(a) >>> 2) : a << ((4 - k) % 4);
         chk(accum_zero_o, e);
      end
      wr(mau_pkg::ADDR_AUC, 16'h0000);
   endtask

   // Operand sources, then multiply-accumulate
   task automatic t_mac();
      wr(mau_pkg::ADDR_A0, 16'h0002);
      wr(mau_pkg::ADDR_A0L, 16'h0007);
      @(posedge ref_clk_i);
      {mrd, maddr, x_load_i, x_src_data_i} <= {3'h4, 2'h3};
      {y_load_i, y_src_i} <= {1'b1, mau_pkg::MAU_YSRC_AHI};
      go();
      rdc(mau_pkg::ADDR_X, 16'h0003);
      rdc(mau_pkg::ADDR_Y, 16'h0002);
      @(posedge ref_clk_i);
      {y_load_i, y_src_i} <= {1'b1, mau_pkg::MAU_YSRC_ALO};
      go();
      rdc(mau_pkg::ADDR_Y, 16'h0007);
      alu(4'h0, 3'h1, 16'h0000, 1'b0, 1'b0);
      mul_en_i <= 1'b1;
      go();
      chk(accum_zero_o, 36'h0_0002_0001);
      rdc(mau_pkg::ADDR_A0L, 16'h0001);
      rdc(mau_pkg::ADDR_PL, 16'h0015);
   endtask

   // All operations and shifts, flags, guards
   task automatic t_alu();
      wr(mau_pkg::ADDR_A0, 16'h8F0F);
      wr(mau_pkg::ADDR_A0L, 16'h00FF);
      for (int i = 0; i < 16; i++) begin
         o = i < 8 ? 4'(i) : 4'(8 + i % 2);
         s = i < 8 ? 0 : (i - 8) / 2;
         alu(o, 3'h4, 16'h8001, 1'b0, 1'b1);
         alu_shift_i <= 2'(s);
         go();
         e = expv(o, sh[s], 36'hF_8F0F_00FF, 36'hF_8001_0000);
         chk(accum_one_o, e);
      end
      alu(4'h2, 3'h4, 16'h0000, 1'b0, 1'b1);
      go();
      chk({32'h0, alu_flags_o}, 36'h4);
      rdc(mau_pkg::ADDR_PSW, 16'h400F);
   endtask

   // Overflow: saturate up, down, off
   task automatic t_sat();
      for (int k = 0; k < 3; k++) begin
         wr(mau_pkg::ADDR_AUC, k < 2 ? 16'h0008 : 16'h0000);
         wr(mau_pkg::ADDR_A0, k == 1 ? 16'h8000 : 16'h7FFF);
         wr(mau_pkg::ADDR_A0L, k == 1 ? 16'h1234 : 16'h0000);
         alu(k == 1 ? 4'h1 : 4'h0, 3'h0, 16'h0100, 1'b0, 1'b0);
         go();
         e = k == 0 ? 36'h0_7FFF_FFFF : 36'hF_8000_0000;
         e = k == 2 ? 36'h0_8006_0000 : e;
         chk(accum_zero_o, e);
      end
   endtask

   // Low clear, generator reset, square
   task automatic t_ctl();
      for (int k = 0; k < 2; k++) begin
         wr(mau_pkg::ADDR_AUC, k ? 16'h0102 : 16'h0000);
         wr(mau_pkg::ADDR_A0L, 16'h1234);
         wr(mau_pkg::ADDR_A0, 16'h0001);
         e = k ? 36'h0_0001_0000 : 36'h0_0001_1234;
         chk(accum_zero_o, e);
         wr(mau_pkg::ADDR_PI, 16'h0000);
         chk({35'h0, psg_reset_o}, 36'(k));
      end
      wr(mau_pkg::ADDR_AUC, 16'h0080);
      @(posedge ref_clk_i);
      {mrd, maddr, y_load_i, y_src_i} <= {3'h7, 1'b1, 2'h0};
      go();
      @(posedge ref_clk_i);
      mul_en_i <= 1'b1;
      go();
      rdc(mau_pkg::ADDR_PL, 16'h0019);
   endtask

   // Loop counters: test sees pre-step sign
   task automatic t_ctr();
      for (int k = 0; k < 3; k++) begin
         wr(mau_pkg::ADDR_C0 + 5'(k), 16'h00FF);
         @(posedge ref_clk_i);
         {ctr_sel_i, ctr_test_i, ctr_step_i} <= {2'(k), 2'h3};
         go();
         chk({35'h0, loop_neg_o}, 36'h1);
         @(posedge ref_clk_i);
         ctr_test_i <= 1'b1;
         go();
         chk({35'h0, loop_neg_o}, 36'h0);
      end
   endtask

   // Main sequence
   initial begin
      {reg_wr_i, reg_rd_i, ins_valid_i, mul_en_i, x_load_i, mrd} = '0;
      {x_src_data_i, y_load_i, y_acc_sel_i, alu_en_i, alu_a_sel_i} = '0;
      {alu_dst_i, ctr_step_i, ctr_test_i, y_src_i, alu_shift_i} = '0;
      {ctr_sel_i, maddr, alu_b_sel_i, alu_op_i, reg_addr_i} = '0;
      {reg_wdata_i, alu_imm_i} = '0;
      n_fail = 0;
      compares = 0;
      reset_i = 1'b1;
      repeat (8) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_mult();
      t_mac();
      t_alu();
      t_sat();
      t_ctl();
      t_ctr();
      complete_run();
   end

   // Watchdog, 5000 cycles
   initial begin
      #20000;
      n_fail++;
      complete_run();
   end
endmodule
